// File: logic/cnt_pkg.sv
// Purpose: constants and types for the encoder up/down counter
// Assumes: 100 MHz sys_clk, APB register access
// Notes:   register offsets are byte addresses of aligned words
//
// Function
// - one 32-bit binary up/down count register
// - two-phase or single-phase counting, gate qualified
// - inputs phase A/up, phase B/down, index clear
// - counts inputs up to 500 kHz, 50% duty
// - programmable input filter, 0.1 us up, bypassable
// - compare match: interrupt, output; match 0 also preset or clear
// - notification line to host on selectable pin
// - card identity taken from board switch
// - control input: preset, clear, start/stop, or input
// - five events: two matches, two errors, carry/borrow
// - five events merged onto one notification output
// - one-shot output width from five durations
package cnt_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_PRESET  = 8'h08;
  localparam logic [7:0] ADDR_CMP0    = 8'h0c;
  localparam logic [7:0] ADDR_CMP1    = 8'h10;
  localparam logic [7:0] ADDR_FILTER  = 8'h14;
  localparam logic [7:0] ADDR_EVENTS  = 8'h18;
  localparam logic [7:0] ADDR_MASK    = 8'h1c;
  localparam logic [7:0] ADDR_OUTCFG  = 8'h20;
  localparam logic [7:0] ADDR_STATUS  = 8'h24;

  // ****************************************
  // control fields
  // ****************************************
  localparam int CTRL_RUN       = 0;
  localparam int CTRL_SINGLE    = 1;
  localparam int CTRL_GATE_EN   = 2;
  localparam int CTRL_GATE_POL  = 3;
  localparam int CTRL_IDX_CLR   = 4;
  localparam int CTRL_M0_PRESET = 5;
  localparam int CTRL_M0_CLEAR  = 6;
  localparam int CTRL_CIN_LO    = 8;
  localparam int CTRL_CIN_HI    = 9;
  localparam int CTRL_CIN_FALL  = 10;
  localparam int CTRL_PIN_LO    = 12;
  localparam int CTRL_PIN_HI    = 13;

  // event bits
  localparam int EV_MATCH0 = 0;
  localparam int EV_MATCH1 = 1;
  localparam int EV_FILTER = 2;
  localparam int EV_ABNORM = 3;
  localparam int EV_CARRY  = 4;
  localparam int EV_NUM    = 5;

  localparam int NOTIFY_PINS = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ         = 100;
  localparam int FILTER_STEP_NS  = 100;
  localparam int FILTER_STEP_CYC = (FILTER_STEP_NS * CLK_MHZ) / 1000;
  localparam int FILTER_MAX_STEP = 16384;       // 1.6384 ms in 0.1 us steps
  localparam int MIN_HALF_NS     = 1000;         // half period at 500 kHz
  localparam int MIN_HALF_CYC    = (MIN_HALF_NS * CLK_MHZ) / 1000;
  localparam int SHOT_US0 = 10;
  localparam int SHOT_US1 = 100;
  localparam int SHOT_US2 = 1000;
  localparam int SHOT_US3 = 10000;
  localparam int SHOT_US4 = 100000;

  typedef enum logic [2:0] {
    OUT_MATCH0, OUT_MATCH1, OUT_FILTER, OUT_ABNORM, OUT_LEVEL
  } out_src_t;

  typedef enum logic [1:0] {
    CIN_PRESET, CIN_CLEAR, CIN_STARTSTOP, CIN_INPUT
  } cin_mode_t;

endpackage : cnt_pkg

// File: logic/encoder_updown_counter.sv
// Purpose: 32-bit up/down encoder counter with APB registers
// Assumes: all pins synchronous to sys_clk
// Notes:   APB answers with zero wait states
`timescale 1ns/1ns
module encoder_updown_counter
  import cnt_pkg::*;
#(
  parameter int          CNT_W   = 32,
  parameter int          SHOT_W  = 24,
  parameter logic [31:0] SHOT_US_TICKS = 32'(CLK_MHZ)
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   phase_a_in,
  input  wire logic                   phase_b_in,
  input  wire logic                   index_clear_in,
  input  wire logic                   gate_in,
  input  wire logic                   control_in,
  input  wire logic [2:0]             card_identity_switch,
  output logic                        control_out,
  output logic      [NOTIFY_PINS-1:0] notify_out
);

  // ****************************************
  // registers and state
  // ****************************************
  logic [31:0]        ctrl_q, ctrl_d, preset_q, preset_d, cmp0_q, cmp0_d, cmp1_q, cmp1_d;
  logic [14:0]        filt_q, filt_d;
  logic [EV_NUM-1:0]  ev_q, ev_d, mask_q, mask_d;
  logic [7:0]         outcfg_q, outcfg_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic [2:0]         id_q, id_d;
  logic               strap_q;
  logic               a_q, b_q, z_q, cin_q, a_d, b_d, z_d, cin_d;
  logic [7:0]         last_q, last_d;       // sample period since last edge
  logic [SHOT_W-1:0]  shot_q, shot_d;
  logic               out_q, out_d;
  logic [NOTIFY_PINS-1:0] notify_q, notify_d;
  logic [31:0]        rdata_q, rdata_d;
  logic               a_f, b_f, z_f, cin_f, a_g, b_g, z_g, cin_g;

  // ****************************************
  // input filters
  // ****************************************
  input_filter #(.STEP_W(15)) u_fa (.sys_clk(sys_clk), .rst_n(rst_n), .raw(phase_a_in),
    .bypass(filt_q == '0), .steps(filt_q), .clean(a_f), .glitch(a_g));
  input_filter #(.STEP_W(15)) u_fb (.sys_clk(sys_clk), .rst_n(rst_n), .raw(phase_b_in),
    .bypass(filt_q == '0), .steps(filt_q), .clean(b_f), .glitch(b_g));
  input_filter #(.STEP_W(15)) u_fz (.sys_clk(sys_clk), .rst_n(rst_n), .raw(index_clear_in),
    .bypass(filt_q == '0), .steps(filt_q), .clean(z_f), .glitch(z_g));
  input_filter #(.STEP_W(15)) u_fc (.sys_clk(sys_clk), .rst_n(rst_n), .raw(control_in),
    .bypass(filt_q == '0), .steps(filt_q), .clean(cin_f), .glitch(cin_g));

  // one-shot length in cycles for a width code
  function automatic logic [SHOT_W-1:0] shot_len(input logic [2:0] code);
    logic [31:0] us;
    case (code)
      3'h0:    us = 32'(SHOT_US0);
      3'h1:    us = 32'(SHOT_US1);
      3'h2:    us = 32'(SHOT_US2);
      3'h3:    us = 32'(SHOT_US3);
      default: us = 32'(SHOT_US4);
    endcase
    shot_len = SHOT_W'(us * SHOT_US_TICKS);
  endfunction : shot_len

  // ****************************************
  // counting logic and registers
  // ****************************************
  logic       bus_wr, bus_rd, up, dn, gate_ok, run, cin_edge, hit0, hit1;
  logic [1:0] cin_mode;
  logic [EV_NUM-1:0] ev_set;
  always_comb begin
    ctrl_d = ctrl_q; preset_d = preset_q; cmp0_d = cmp0_q; cmp1_d = cmp1_q;
    filt_d = filt_q; mask_d = mask_q; outcfg_d = outcfg_q;
    id_d = strap_q ? card_identity_switch : id_q;
    a_d = a_f; b_d = b_f; z_d = z_f; cin_d = cin_f;
    bus_wr = psel && penable && pwrite;
    bus_rd = psel && !penable && !pwrite;
    cin_mode = ctrl_q[CTRL_CIN_HI:CTRL_CIN_LO];
    cin_edge = ctrl_q[CTRL_CIN_FALL] ? (cin_q && !cin_f) : (!cin_q && cin_f);
    gate_ok = !ctrl_q[CTRL_GATE_EN] || (gate_in ^ ctrl_q[CTRL_GATE_POL]);
    run = ctrl_q[CTRL_RUN] && gate_ok;
    up = 1'b0;
    dn = 1'b0;
    if (ctrl_q[CTRL_SINGLE]) begin
      up = !a_q && a_f;
      dn = !b_q && b_f;
    end else if ((a_q ^ a_f) || (b_q ^ b_f)) begin
      // 4x quadrature decode: direction from phase relation
      up = (a_f ^ b_q);
      dn = !(a_f ^ b_q);
    end
    if (!run || (up && dn)) begin
      up = 1'b0;
      dn = 1'b0;
    end
    ev_set = '0;
    // both phases moving together means lost quadrature
    ev_set[EV_ABNORM] = !ctrl_q[CTRL_SINGLE] && (a_q ^ a_f) && (b_q ^ b_f);
    // an edge closer than the 500 kHz half period counts as a filter error
    // spacing is last_q + 1; quadrature phases may legally step a quarter period apart
    ev_set[EV_FILTER] = a_g || b_g || (((a_q ^ a_f) || (b_q ^ b_f)) &&
                        (last_q < (ctrl_q[CTRL_SINGLE] ? 8'(MIN_HALF_CYC - 1) :
                                   8'(MIN_HALF_CYC / 2 - 1))));
    last_d = ((a_q ^ a_f) || (b_q ^ b_f)) ? 8'h00 :
             ((last_q == 8'hff) ? last_q : last_q + 8'h01);
    cnt_d = cnt_q;
    if (up) begin
      cnt_d = cnt_q + 1'b1;
      ev_set[EV_CARRY] = &cnt_q;
    end else if (dn) begin
      cnt_d = cnt_q - 1'b1;
      ev_set[EV_CARRY] = (cnt_q == '0);
    end
    hit0 = (up || dn) && (cnt_d == CNT_W'(cmp0_q));
    hit1 = (up || dn) && (cnt_d == CNT_W'(cmp1_q));
    ev_set[EV_MATCH0] = hit0;
    ev_set[EV_MATCH1] = hit1;
    if (hit0 && ctrl_q[CTRL_M0_PRESET]) cnt_d = CNT_W'(preset_q);
    if (hit0 && ctrl_q[CTRL_M0_CLEAR])  cnt_d = '0;
    if (ctrl_q[CTRL_IDX_CLR] && !z_q && z_f) cnt_d = '0;
    if (cin_edge && cin_mode == CIN_PRESET) cnt_d = CNT_W'(preset_q);
    if (cin_edge && cin_mode == CIN_CLEAR)  cnt_d = '0;
    if (cin_edge && cin_mode == CIN_STARTSTOP) ctrl_d[CTRL_RUN] = !ctrl_q[CTRL_RUN];
    ev_d = ev_q | ev_set;
    if (bus_wr) begin
      case (paddr)
        ADDR_CTRL:   ctrl_d   = pwdata;
        ADDR_COUNT:  cnt_d    = CNT_W'(pwdata);
        ADDR_PRESET: preset_d = pwdata;
        ADDR_CMP0:   cmp0_d   = pwdata;
        ADDR_CMP1:   cmp1_d   = pwdata;
        ADDR_FILTER: filt_d   = pwdata[14:0];
        ADDR_EVENTS: ev_d     = (ev_q & ~pwdata[EV_NUM-1:0]) | ev_set; // set beats clear
        ADDR_MASK:   mask_d   = pwdata[EV_NUM-1:0];
        ADDR_OUTCFG: outcfg_d = pwdata[7:0];
        default:     ;
      endcase
    end
    rdata_d = rdata_q;
    if (bus_rd) begin
      case (paddr)
        ADDR_CTRL:   rdata_d = ctrl_q;
        ADDR_COUNT:  rdata_d = 32'(cnt_q);
        ADDR_PRESET: rdata_d = preset_q;
        ADDR_CMP0:   rdata_d = cmp0_q;
        ADDR_CMP1:   rdata_d = cmp1_q;
        ADDR_FILTER: rdata_d = {17'h00000, filt_q};
        ADDR_EVENTS: rdata_d = {27'h0000000, ev_q};
        ADDR_MASK:   rdata_d = {27'h0000000, mask_q};
        ADDR_OUTCFG: rdata_d = {24'h000000, outcfg_q};
        ADDR_STATUS: rdata_d = {24'h000000, id_q, 1'b0, cin_q, z_q, b_q, a_q};
        default:     rdata_d = 32'h00000000;
      endcase
    end
    // control output: one-shot on selected source, or level
    out_d  = out_q;
    shot_d = shot_q;
    if (out_src_t'(outcfg_q[2:0]) == OUT_LEVEL) begin
      out_d = outcfg_q[3] ^ outcfg_q[7];
    end else if (ev_set[outcfg_q[2:0]]) begin
      shot_d = shot_len(outcfg_q[6:4]);
      out_d  = !outcfg_q[7];
    end else if (shot_q != '0) begin
      shot_d = shot_q - 1'b1;
    end else begin
      out_d = outcfg_q[7];
    end
    notify_d = '0;
    notify_d[ctrl_q[CTRL_PIN_HI:CTRL_PIN_LO]] = |(ev_q & mask_q);
  end

  // strap catch: identity taken on the first clock after reset release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) strap_q <= 1'b1;
    else        strap_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0; preset_q <= '0; cmp0_q <= '0; cmp1_q <= '0;
      filt_q <= '0; ev_q <= '0; mask_q <= '0; outcfg_q <= '0;
      cnt_q <= '0; id_q <= '0; a_q <= 1'b0; b_q <= 1'b0; z_q <= 1'b0;
      cin_q <= 1'b0; last_q <= 8'hff; shot_q <= '0; out_q <= 1'b0;
      notify_q <= '0; rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d; preset_q <= preset_d; cmp0_q <= cmp0_d; cmp1_q <= cmp1_d;
      filt_q <= filt_d; ev_q <= ev_d; mask_q <= mask_d; outcfg_q <= outcfg_d;
      cnt_q <= cnt_d; id_q <= id_d; a_q <= a_d; b_q <= b_d; z_q <= z_d;
      cin_q <= cin_d; last_q <= last_d; shot_q <= shot_d; out_q <= out_d;
      notify_q <= notify_d; rdata_q <= rdata_d;
    end
  end

  assign prdata      = rdata_q;
  assign pready      = 1'b1;
  assign pslverr     = 1'b0;
  assign control_out = out_q;
  assign notify_out  = notify_q;

endmodule : encoder_updown_counter

// File: logic/input_filter.sv
// Purpose: digital glitch filter for one count input
// Assumes: input synchronous to sys_clk
// Notes:   a changed level must stand steady for the set time
`timescale 1ns/1ns
module input_filter
  import cnt_pkg::*;
#(
  parameter int STEP_W = 15
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              raw,
  input  wire logic              bypass,
  input  wire logic [STEP_W-1:0] steps,
  output logic                   clean,
  output logic                   glitch
);

  logic [STEP_W-1:0] step_q, step_d;
  logic [3:0]        pre_q, pre_d;
  logic              clean_q, clean_d;
  logic              glitch_q, glitch_d;

  // ****************************************
  // settle counter
  // ****************************************
  // a level must hold steps x 0.1 us; a bounce before that is reported
  always_comb begin
    step_d   = step_q;
    pre_d    = pre_q;
    clean_d  = clean_q;
    glitch_d = 1'b0;
    if (bypass) begin
      clean_d = raw;
      step_d  = '0;
      pre_d   = '0;
    end else if (raw == clean_q) begin
      glitch_d = (step_q != '0) || (pre_q != '0);
      step_d   = '0;
      pre_d    = '0;
    end else if (pre_q != 4'(FILTER_STEP_CYC - 1)) begin
      pre_d = pre_q + 4'h1;
    end else begin
      pre_d = '0;
      // the last step accepts, so a setting of n waits n x 0.1 us, not n + 1
      if (step_q >= steps - STEP_W'(1)) begin
        clean_d = raw;
        step_d  = '0;
      end else begin
        step_d = step_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q   <= '0;
      pre_q    <= '0;
      clean_q  <= 1'b0;
      glitch_q <= 1'b0;
    end else begin
      step_q   <= step_d;
      pre_q    <= pre_d;
      clean_q  <= clean_d;
      glitch_q <= glitch_d;
    end
  end

  assign clean  = clean_q;
  assign glitch = glitch_q;

endmodule : input_filter

// File: tb/cnt_chk.sv
// Purpose: port checks for encoder_updown_counter
// Assumes: zero-wait APB, one clock domain
// Notes:   shadows notify pin choice and output config from bus writes
`timescale 1ns/1ns
module cnt_chk
  import cnt_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [2:0]             card_identity_switch,
  input wire logic                   control_out,
  input wire logic [NOTIFY_PINS-1:0] notify_out
);
  logic       rd_q;
  logic [7:0] ra_q;
  logic [1:0] pin_q;
  logic [7:0] ocfg_q;
  // shadow copies; a write lands at the access edge, as in the block
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q   <= 1'b0;
      ra_q   <= 8'h00;
      pin_q  <= 2'h0;
      ocfg_q <= 8'h00;
    end else begin
      rd_q <= psel && !penable && !pwrite;
      ra_q <= paddr;
      if (psel && penable && pwrite && paddr == ADDR_CTRL) pin_q <= pwdata[13:12];
      if (psel && penable && pwrite && paddr == ADDR_OUTCFG) ocfg_q <= pwdata[7:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_PREADY: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  AST_NO_ERR: assert property (psel && penable |-> !pslverr)
    else $error("pslverr raised");
  AST_ONE_PIN: assert property ($onehot0(notify_out))
    else $error("more than one notify pin active");
  // one cycle of slack after a pin change, since the output is registered
  AST_PIN_SEL: assert property ($stable(pin_q) |-> (notify_out & ~(4'h1 << pin_q)) == 4'h0)
    else $error("notify on unselected pin");
  AST_READ_HOLD: assert property (!rd_q |-> $stable(prdata))
    else $error("read data moved without a read");
  AST_ID: assert property (rd_q && ra_q == ADDR_STATUS |-> prdata[7:5] == card_identity_switch)
    else $error("identity field wrong");
  AST_UNMAPPED: assert property (rd_q && ra_q > ADDR_STATUS |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_GP_LEVEL: assert property (ocfg_q[2:0] == 3'h4 && $stable(ocfg_q)
    |-> control_out == (ocfg_q[3] ^ ocfg_q[7]))
    else $error("level output wrong");
  cover property (rd_q && ra_q == ADDR_COUNT);
  cover property ($rose(control_out));
  cover property (notify_out != 4'h0);
endmodule : cnt_chk

// File: tb/encoder_source.sv
// Purpose: encoder or scale model driving the three count inputs
// Assumes: tasks are called just after a rising clock edge
// Notes:   edges move on rising edges only, like a synchronised source
`timescale 1ns/1ns
module encoder_source
  import cnt_pkg::*;
(
  input wire logic sys_clk,
  output logic     phase_a_in,
  output logic     phase_b_in,
  output logic     index_clear_in
);
  logic [2:0] lines_q = 3'h0;
  logic [1:0] ph      = 2'h0;
  assign {index_clear_in, phase_b_in, phase_a_in} = lines_q;
  // quarter-period spacing keeps the pair within the top input rate
  task automatic quad(input int n, input bit up);
    for (int i = 0; i < n; i++) begin
      repeat (MIN_HALF_CYC / 2) @(posedge sys_clk);
      ph = up ? ph + 2'h1 : ph - 2'h1;
      lines_q[1:0] <= {ph[1], ph[1] ^ ph[0]};
    end
  endtask : quad
  // sel 0 up line, 1 down line, 2 index; short widths only as glitches
  task pulse(input int sel, input int width);
    @(posedge sys_clk);
    lines_q[sel] <= 1'b1;
    repeat (width) @(posedge sys_clk);
    lines_q[sel] <= 1'b0;
    repeat (width) @(posedge sys_clk);
  endtask : pulse
endmodule : encoder_source

// File: tb/tb.sv
// Purpose: register-level tests of encoder_updown_counter
// Assumes: zero-wait APB; one-shot tick shortened to one cycle per us
// Notes:   quadrature counts up when phase A leads
`timescale 1ns/1ns
module tb;
  import cnt_pkg::*;
  logic        sys_clk, rst_n, psel, penable, pwrite, gate_in, control_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, phase_a_in, phase_b_in, index_clear_in, control_out;
  logic [2:0]  card_identity_switch;
  logic [3:0]  notify_out;
  int          n_fail, samples_checked, cycles, run_w, shot_w;
  encoder_updown_counter #(.SHOT_US_TICKS(32'd1)) u_encoder_updown_counter (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a_in(phase_a_in), .phase_b_in(phase_b_in), .index_clear_in(index_clear_in),
    .gate_in(gate_in), .control_in(control_in), .card_identity_switch(card_identity_switch),
    .control_out(control_out), .notify_out(notify_out));
  encoder_source u_encoder_source (.sys_clk(sys_clk), .phase_a_in(phase_a_in),
    .phase_b_in(phase_b_in), .index_clear_in(index_clear_in));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // width of the last high run on the control output; hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (control_out === 1'b1) run_w++;
    else if (run_w != 0) begin
      shot_w = run_w;
      run_w = 0;
    end
    if (cycles == 30000) begin
      n_fail++;
      close_out();
    end
  end
  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    repeat (8) @(posedge sys_clk);
    apb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rd_chk
  task automatic ctl_pulse();
    @(posedge sys_clk) control_in <= 1'b1;
    repeat (20) @(posedge sys_clk);
    control_in <= 1'b0;
    repeat (20) @(posedge sys_clk);
  endtask : ctl_pulse
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; gate_in = 1'b0; control_in = 1'b0; card_identity_switch = 3'h5;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(ADDR_STATUS, 32'he0, 32'ha0);
    rd_chk(8'h28, 32'hffffffff, 32'h0);
    $display("identity test done");
    wr(ADDR_PRESET, 32'hfffffffe);
    wr(ADDR_CTRL, 32'h00002001);
    ctl_pulse();
    rd_chk(ADDR_COUNT, 32'hffffffff, 32'hfffffffe);
    u_encoder_source.quad(4, 1'b1);
    rd_chk(ADDR_COUNT, 32'hffffffff, 32'h2);
    rd_chk(ADDR_EVENTS, 32'h10, 32'h10);
    wr(ADDR_MASK, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk(32'(notify_out), 32'h4);
    wr(ADDR_EVENTS, 32'h1f);
    rd_chk(ADDR_EVENTS, 32'h1f, 32'h0);
    chk(32'(notify_out), 32'h0);
    u_encoder_source.quad(4, 1'b0);
    rd_chk(ADDR_COUNT, 32'hffffffff, 32'hfffffffe);
    rd_chk(ADDR_EVENTS, 32'h1c, 32'h10);
    $display("wrap test done");
    wr(ADDR_CTRL, 32'h00000011);
    u_encoder_source.pulse(2, MIN_HALF_CYC);
    rd_chk(ADDR_COUNT, 32'hffffffff, 32'h0);
    wr(ADDR_CTRL, 32'h00000007);
    for (int i = 0; i < 2; i++) u_encoder_source.pulse(0, MIN_HALF_CYC);
    rd_chk(ADDR_COUNT, 32'hffffffff, 32'h0);
    gate_in <= 1'b1;
    for (int i = 0; i < 4; i++) u_encoder_source.pulse(i == 3, MIN_HALF_CYC);
    rd_chk(ADDR_COUNT, 32'hffffffff, 32'h2);
    wr(ADDR_FILTER, 32'd10);
    u_encoder_source.pulse(0, 50);
    rd_chk(ADDR_COUNT, 32'hffffffff, 32'h2);
    u_encoder_source.pulse(0, 105);
    rd_chk(ADDR_COUNT, 32'hffffffff, 32'h3);
    wr(ADDR_FILTER, 32'd0);
    $display("gate and filter test done");
    wr(ADDR_OUTCFG, 32'h10);
    wr(ADDR_EVENTS, 32'h1f);
    wr(ADDR_CMP0, 32'h5);
    wr(ADDR_CTRL, 32'h00000041);
    u_encoder_source.quad(2, 1'b1);
    rd_chk(ADDR_COUNT, 32'hffffffff, 32'h0);
    rd_chk(ADDR_EVENTS, 32'h1, 32'h1);
    repeat (120) @(posedge sys_clk);
    chk(32'(shot_w inside {SHOT_US1, SHOT_US1 + 1}), 32'h1);
    wr(ADDR_OUTCFG, 32'h0c);
    rd_chk(ADDR_OUTCFG, 32'hff, 32'h0c);
    chk(32'(control_out), 32'h1);
    wr(ADDR_OUTCFG, 32'h8c);
    rd_chk(ADDR_OUTCFG, 32'hff, 32'h8c);
    chk(32'(control_out), 32'h0);
    wr(ADDR_COUNT, 32'h00001234);
    wr(ADDR_CTRL, 32'h00000501);
    ctl_pulse();
    rd_chk(ADDR_COUNT, 32'hffffffff, 32'h0);
    wr(ADDR_CTRL, 32'h00000201);
    ctl_pulse();
    rd_chk(ADDR_CTRL, 32'h1, 32'h0);
    wr(ADDR_CTRL, 32'h00000300);
    control_in <= 1'b1;
    rd_chk(ADDR_STATUS, 32'h8, 32'h8);
    $display("match and output test done");
    close_out();
  end
endmodule : tb
bind encoder_updown_counter cnt_chk u_cnt_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .control_out(control_out),
  .card_identity_switch(card_identity_switch), .notify_out(notify_out));
